// [e3ri_pkg.sv]
// constants for the receive alarm and overhead interrupt flag block
// assumes byte-wide registers, each on one aligned 32-bit APB word
package e3ri_pkg;
   // ==========================================================
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_RX_CONFIG = 6'h10;
   localparam logic [5:0] IDX_RX_CFG_STATUS = 6'h11;
   localparam logic [5:0] IDX_RX_ALARM_ENABLE_ONE = 6'h12;
   localparam logic [5:0] IDX_RX_OVERHEAD_ENABLE_TWO = 6'h13;
   localparam logic [5:0] IDX_RX_ALARM_STATUS_ONE = 6'h14;
   localparam logic [5:0] IDX_RX_OVERHEAD_STATUS_TWO = 6'h15;
   // ==========================================================
   // writable and readable bits of each register
   localparam logic [7:0] RX_CONFIG_MASK = 8'h03;
   localparam logic [7:0] ENABLE_ONE_MASK = 8'h7F;
   localparam logic [7:0] ENABLE_TWO_MASK = 8'h5F;
   localparam logic [7:0] STATUS_ONE_MASK = 8'h7F;
   localparam logic [7:0] STATUS_TWO_MASK = 8'h5F;
   // ==========================================================
   // reset values
   localparam logic [7:0] RX_CONFIG_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // ==========================================================
   // field positions
   localparam int CFG_REV1995_BIT = 0;
   localparam int CFG_FAIL_FIVE_BIT = 1;
   localparam int CFGST_SIGNAL_BIT = 6;
   localparam int CFGST_ALARM_BIT = 7;
   localparam int S1_SYNC_MSG_BIT = 6;
   localparam int S1_SYNC_SEQ_BIT = 5;
   localparam int S1_ALIGN_BIT = 4;
   localparam int S1_OUT_FRAME_BIT = 3;
   localparam int S1_LOST_FRAME_BIT = 2;
   localparam int S1_LOST_SIGNAL_BIT = 1;
   localparam int S1_ALARM_IND_BIT = 0;
   localparam int S2_TRACE_BIT = 6;
   localparam int S2_BLOCK_ERR_BIT = 4;
   localparam int S2_FAR_FAIL_BIT = 3;
   localparam int S2_MONITOR_BIT = 2;
   localparam int S2_FRAMING_BIT = 1;
   localparam int S2_PLD_BIT = 0;
   // ==========================================================
   // received bit and frame counts
   localparam logic [5:0] SIGNAL_ZERO_RUN = 6'h20;
   localparam logic [5:0] SIGNAL_CLEAR_SPAN = 6'h20;
   localparam logic [5:0] SIGNAL_SPACE_RUN = 6'h04;
   localparam logic [2:0] FAIL_FRAMES_SHORT = 3'h3;
   localparam logic [2:0] FAIL_FRAMES_LONG = 3'h5;
endpackage

// [e3ri_rx_alarm_flags.sv]
// receive alarm and overhead interrupt flags for one E3 channel
// assumes the framer runs on ref_clk and hands over bits, frame
// fields and state-change pulses already in this clock domain
//
// Notes on behaviour
// - enable-two bit 4 gates far-end block error; reads back as written
// - enable-two bit 3 gates far-end failure change; read/write
// - enable-two bit 2 gates error-monitor byte error; read/write
// - enable-two bit 1 gates framing byte error; read/write
// - enable-two bit 0 gates payload type mismatch; read/write
// - status-one at 0x14, bit 7 reads zero, others latched, reset zero
// - flag reads one if event since last read; read clears returned flags
// - status-one bit 6 sets when sync status message content changes
// - status-one bit 5 sets on losing and on regaining sequence sync
// - in 1995 mode bits 6 and 5 need not be valid, enables ignored
// - status-one bit 4 sets on change of frame alignment
// - status-one bit 3 sets on out-of-frame entry and on in-frame entry
// - status-one bit 2 sets entering loss-of-frame and verify-to-in-frame
// - loss of signal after 32 zero bits; sets status-one bit 1
// - loss of signal ends after 32 bits without four zeros; sets bit 1
// - live loss of signal readable at 0x11 bit 6
// - status-one bit 0 sets on start and end of alarm indication
// - live alarm indication readable at 0x11 bit 7
// - status-two at 0x15, flags 6,4,3,2,1,0; bits 7,5 zero; reset zero
// - status-two bit 6 sets on trail trace byte with msb one
// - status-two bit 4 sets on every frame with far-end block error one
// - status-two bit 3 sets on far-end failure declare and clear, 3/5 frames
// - status-two bit 0 sets when payload type differs from previous frame
`timescale 1ns/100ps
`default_nettype none

module e3ri_rx_alarm_flags
(
   input wire logic ref_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // line bits from the receive interface
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   // framer state and frame overhead
   input wire logic alarm_indication_signal,
   input wire logic sequence_lost,
   input wire logic frame_alignment_change,
   input wire logic out_of_frame_enter,
   input wire logic in_frame_enter,
   input wire logic loss_of_frame_enter,
   input wire logic verify_to_in_frame,
   input wire logic frame_valid,
   input wire logic far_end_block_error_flag,
   input wire logic far_end_receive_failure,
   input wire logic [2:0] payload_type,
   input wire logic [3:0] sync_status_message,
   input wire logic [7:0] trail_trace_buffer,
   input wire logic error_monitor_byte_error,
   input wire logic framing_byte_error,
   // channel interrupt request
   output logic irq
);

   // ==========================================================
   // helpers
   function automatic logic [7:0] flag_update
   (
      input logic [7:0] flags,
      input logic [7:0] events,
      input logic [7:0] clr,
      input logic [7:0] mask
   );
      // set wins over the clear
      flag_update = ((flags & ~clr) | events) & mask;
   endfunction

   function automatic logic [5:0] sat_inc
   (
      input logic [5:0] val,
      input logic [5:0] lim
   );
      sat_inc = (val >= lim) ? lim : val + 6'h01;
   endfunction

   // ==========================================================
   // apb decode
   logic [7:0] rx_config_ff;
   logic [7:0] enable_one_ff;
   logic [7:0] enable_two_ff;
   logic [7:0] status_one_ff;
   logic [7:0] status_two_ff;
   logic sig_lost_ff;
   logic alarm_ind_ff;
   logic [7:0] snap_one_ff;
   logic [7:0] snap_two_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;

   wire [5:0] reg_idx = paddr[7:2];
   wire aligned = (paddr[1:0] == 2'h0);
   wire hit_cfg = aligned && (reg_idx == e3ri_pkg::IDX_RX_CONFIG);
   wire hit_cst = aligned && (reg_idx == e3ri_pkg::IDX_RX_CFG_STATUS);
   wire hit_en1 = aligned && (reg_idx == e3ri_pkg::IDX_RX_ALARM_ENABLE_ONE);
   wire hit_en2 = aligned && (reg_idx == e3ri_pkg::IDX_RX_OVERHEAD_ENABLE_TWO);
   wire hit_st1 = aligned && (reg_idx == e3ri_pkg::IDX_RX_ALARM_STATUS_ONE);
   wire hit_st2 = aligned && (reg_idx == e3ri_pkg::IDX_RX_OVERHEAD_STATUS_TWO);
   wire mapped = hit_cfg | hit_cst | hit_en1 | hit_en2 | hit_st1 | hit_st2;

   wire setup_phase = psel && !penable;
   // pready is high only in the access cycle that follows setup
   wire complete = psel && penable && pready_ff;
   wire wr_low = complete && pwrite && pstrb[0] && !pslverr_ff;
   wire rd_done = complete && !pwrite && !pslverr_ff;

   wire cfg_rev1995 = rx_config_ff[e3ri_pkg::CFG_REV1995_BIT];
   wire cfg_fail_five = rx_config_ff[e3ri_pkg::CFG_FAIL_FIVE_BIT];

   // ==========================================================
   // loss of signal detector
   logic [5:0] zero_run_ff;
   logic [5:0] clean_run_ff;

   wire [5:0] nxt_zero_run = rx_bit ? 6'h00
      : sat_inc(zero_run_ff, e3ri_pkg::SIGNAL_ZERO_RUN);
   // any run of four zeros restarts the clean span
   wire [5:0] nxt_clean_run = (nxt_zero_run >= e3ri_pkg::SIGNAL_SPACE_RUN) ? 6'h00
      : sat_inc(clean_run_ff, e3ri_pkg::SIGNAL_CLEAR_SPAN);
   wire sig_lost_enter = rx_bit_valid && !sig_lost_ff
      && (nxt_zero_run == e3ri_pkg::SIGNAL_ZERO_RUN);
   wire sig_lost_exit = rx_bit_valid && sig_lost_ff
      && (nxt_clean_run == e3ri_pkg::SIGNAL_CLEAR_SPAN);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         zero_run_ff <= 6'h00;
         clean_run_ff <= 6'h00;
         sig_lost_ff <= 1'b0;
      end
      else if (rx_bit_valid)
      begin
         zero_run_ff <= nxt_zero_run;
         clean_run_ff <= nxt_clean_run;
         if (sig_lost_enter)
            sig_lost_ff <= 1'b1;
         else if (sig_lost_exit)
            sig_lost_ff <= 1'b0;
      end
   end

   // ==========================================================
   // alarm indication and sequence sync edges
   logic seq_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         alarm_ind_ff <= 1'b0;
         seq_ff <= 1'b0;
      end
      else
      begin
         alarm_ind_ff <= alarm_indication_signal;
         seq_ff <= sequence_lost;
      end
   end

   wire alarm_ind_change = alarm_indication_signal ^ alarm_ind_ff;
   wire seq_change = sequence_lost ^ seq_ff;

   // ==========================================================
   // far-end failure over 3 or 5 consecutive frames
   logic fail_state_ff;
   logic [2:0] fail_cnt_ff;

   wire [2:0] fail_need = cfg_fail_five ? e3ri_pkg::FAIL_FRAMES_LONG
      : e3ri_pkg::FAIL_FRAMES_SHORT;
   wire fail_differs = far_end_receive_failure ^ fail_state_ff;
   wire [2:0] nxt_fail_cnt = fail_differs ? fail_cnt_ff + 3'h1 : 3'h0;
   wire fail_toggle = frame_valid && (nxt_fail_cnt >= fail_need);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fail_state_ff <= 1'b0;
         fail_cnt_ff <= 3'h0;
      end
      else if (frame_valid)
      begin
         fail_cnt_ff <= fail_toggle ? 3'h0 : nxt_fail_cnt;
         if (fail_toggle)
            fail_state_ff <= !fail_state_ff;
      end
   end

   // ==========================================================
   // previous frame payload type and sync status message
   logic have_prev_ff;
   logic [2:0] prev_pld_ff;
   logic [3:0] prev_sync_msg_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         have_prev_ff <= 1'b0;
         prev_pld_ff <= 3'h0;
         prev_sync_msg_ff <= 4'h0;
      end
      else if (frame_valid)
      begin
         have_prev_ff <= 1'b1;
         prev_pld_ff <= payload_type;
         prev_sync_msg_ff <= sync_status_message;
      end
   end

   // first frame after reset has nothing to compare against
   wire pld_change = frame_valid && have_prev_ff
      && (payload_type != prev_pld_ff);
   wire sync_msg_change = frame_valid && have_prev_ff
      && (sync_status_message != prev_sync_msg_ff);

   // ==========================================================
   // event vectors
   logic [7:0] ev_one;
   logic [7:0] ev_two;

   always_comb
   begin
      ev_one = 8'h00;
      // 1995 format carries no message fields, so hold these off
      ev_one[e3ri_pkg::S1_SYNC_MSG_BIT] = sync_msg_change && !cfg_rev1995;
      ev_one[e3ri_pkg::S1_SYNC_SEQ_BIT] = seq_change && !cfg_rev1995;
      ev_one[e3ri_pkg::S1_ALIGN_BIT] = frame_alignment_change;
      ev_one[e3ri_pkg::S1_OUT_FRAME_BIT] = out_of_frame_enter | in_frame_enter;
      ev_one[e3ri_pkg::S1_LOST_FRAME_BIT] = loss_of_frame_enter | verify_to_in_frame;
      ev_one[e3ri_pkg::S1_LOST_SIGNAL_BIT] = sig_lost_enter | sig_lost_exit;
      ev_one[e3ri_pkg::S1_ALARM_IND_BIT] = alarm_ind_change;
      ev_two = 8'h00;
      ev_two[e3ri_pkg::S2_TRACE_BIT] = frame_valid && trail_trace_buffer[7];
      ev_two[e3ri_pkg::S2_BLOCK_ERR_BIT] = frame_valid && far_end_block_error_flag;
      ev_two[e3ri_pkg::S2_FAR_FAIL_BIT] = fail_toggle;
      ev_two[e3ri_pkg::S2_MONITOR_BIT] = frame_valid && error_monitor_byte_error;
      ev_two[e3ri_pkg::S2_FRAMING_BIT] = frame_valid && framing_byte_error;
      ev_two[e3ri_pkg::S2_PLD_BIT] = pld_change;
   end

   // ==========================================================
   // latched flags
   // clear only what the host was shown at setup, so a flag set
   // between setup and access survives
   wire [7:0] clr_one = rd_done && hit_st1 ? snap_one_ff : 8'h00;
   wire [7:0] clr_two = rd_done && hit_st2 ? snap_two_ff : 8'h00;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         status_one_ff <= e3ri_pkg::STATUS_RESET;
         status_two_ff <= e3ri_pkg::STATUS_RESET;
      end
      else
      begin
         status_one_ff <= flag_update(status_one_ff, ev_one, clr_one,
            e3ri_pkg::STATUS_ONE_MASK);
         status_two_ff <= flag_update(status_two_ff, ev_two, clr_two,
            e3ri_pkg::STATUS_TWO_MASK);
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rx_config_ff <= e3ri_pkg::RX_CONFIG_RESET;
         enable_one_ff <= e3ri_pkg::ENABLE_RESET;
         enable_two_ff <= e3ri_pkg::ENABLE_RESET;
      end
      else if (wr_low)
      begin
         if (hit_cfg)
            rx_config_ff <= pwdata[7:0] & e3ri_pkg::RX_CONFIG_MASK;
         if (hit_en1)
            enable_one_ff <= pwdata[7:0] & e3ri_pkg::ENABLE_ONE_MASK;
         if (hit_en2)
            enable_two_ff <= pwdata[7:0] & e3ri_pkg::ENABLE_TWO_MASK;
      end
   end

   // ==========================================================
   // interrupt request
   logic [7:0] eff_en_one;

   always_comb
   begin
      eff_en_one = enable_one_ff;
      if (cfg_rev1995)
      begin
         eff_en_one[e3ri_pkg::S1_SYNC_MSG_BIT] = 1'b0;
         eff_en_one[e3ri_pkg::S1_SYNC_SEQ_BIT] = 1'b0;
      end
   end

   // enable-two gates trace, block error, far-end failure, monitor, framing, payload
   wire gate_two = |(status_two_ff & enable_two_ff);
   wire gate_one = |(status_one_ff & eff_en_one);
   // follows the flags, so it drops one cycle after a clearing read
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq_ff <= 1'b0;
      else
         irq_ff <= gate_one | gate_two;
   end

   // ==========================================================
   // read mux and bus answer
   wire [7:0] cfg_status_rd = {alarm_ind_ff, sig_lost_ff, 6'h00};
   logic [7:0] rd_byte;

   always_comb
   begin
      rd_byte = 8'h00;
      if (hit_cfg)
         rd_byte = rx_config_ff;
      if (hit_cst)
         rd_byte = cfg_status_rd;
      if (hit_en1)
         rd_byte = enable_one_ff;
      if (hit_en2)
         rd_byte = enable_two_ff;
      if (hit_st1)
         rd_byte = status_one_ff;
      if (hit_st2)
         rd_byte = status_two_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         snap_one_ff <= 8'h00;
         snap_two_ff <= 8'h00;
      end
      else if (setup_phase)
      begin
         pready_ff <= 1'b1;
         pslverr_ff <= !mapped;
         prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         snap_one_ff <= status_one_ff;
         snap_two_ff <= status_two_ff;
      end
      else
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;

endmodule

`default_nettype wire

// [e3ri_rx_alarm_flags_asserts.sv]
// checker for the receive alarm flag block, watching its top ports only
// assumes one clock, ref_clk, and synchronous active-high rst
`timescale 1ns/100ps
`default_nettype none

module e3ri_rx_alarm_flags_chk
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_valid,
   input wire logic far_end_block_error_flag,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // shadow of enable-two, rebuilt from completed writes
   logic [7:0] en2_ff;
   logic wr_en2;
   logic rd_acc;
   assign wr_en2 = psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h4C;
   assign rd_acc = pready && !pwrite && !pslverr;
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         en2_ff <= 8'h00;
      else if (wr_en2)
         en2_ff <= pwdata[7:0] & e3ri_pkg::ENABLE_TWO_MASK;
   end
   // ==========================================================
   // assertions
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0
      |=> pready && pslverr) else $error("unaligned access not refused");
   chk_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   chk_status_one_top: assert property (rd_acc && paddr == 8'h50 |-> !prdata[7])
      else $error("status one bit 7 set");
   chk_status_two_gaps: assert property (rd_acc && paddr == 8'h54 |->
      prdata[7] == 1'b0 && prdata[5] == 1'b0) else $error("status two unused bit set");
   chk_enable_readback: assert property (rd_acc && paddr == 8'h4C |->
      prdata[7:0] == en2_ff) else $error("enable two readback wrong");
   chk_block_error_irq: assert property (frame_valid && far_end_block_error_flag
      && en2_ff[4] ##1 en2_ff[4] |=> irq)
      else $error("block error did not raise irq");
   chk_reset_quiet: assert property ($fell(rst) |-> !irq && !pready && prdata == 32'h0)
      else $error("outputs not idle after reset");
   // ==========================================================
   // covers
   cov_block_error_irq: cover property (frame_valid && far_end_block_error_flag ##2 irq);
   cov_refused: cover property (pready && pslverr);
   cov_status_read: cover property (rd_acc && paddr == 8'h50 && prdata[7:0] != 8'h00);
endmodule

bind e3ri_rx_alarm_flags e3ri_rx_alarm_flags_chk u_chk (.ref_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .frame_valid,
   .far_end_block_error_flag, .irq);

`default_nettype wire

// [e3ri_host_model.sv]
// apb master standing in for the host microprocessor
// assumes one request pulse on go while idle; done pulses at completion
`timescale 1ns/100ps
`default_nettype none

module e3ri_host_model
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   output logic done,
   output logic [31:0] rdata,
   output logic err,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic sel_ff = 1'b0;
   logic en_ff = 1'b0;
   logic wr_ff = 1'b0;
   logic [7:0] addr_ff = 8'h00;
   logic [31:0] data_ff = 32'h0;
   assign {psel, penable, pwrite, paddr, pwdata} = {sel_ff, en_ff, wr_ff, addr_ff, data_ff};
   assign pstrb = 4'hF;
   always_ff @(posedge ref_clk)
   begin
      done <= 1'b0;
      if (rst)
         {sel_ff, en_ff} <= 2'h0;
      else if (go && !sel_ff)
         {sel_ff, wr_ff, addr_ff, data_ff} <= {1'b1, wr, addr, wdata};
      else if (sel_ff && !en_ff)
         en_ff <= 1'b1;
      else if (en_ff && pready)
      begin
         // released lines stop showing the old value
         {sel_ff, en_ff, addr_ff, data_ff} <= {2'h0, ~addr_ff, ~data_ff};
         {rdata, err, done} <= {prdata, pslverr, 1'b1};
      end
   end
endmodule

`default_nettype wire

// [testbench.sv]
// self-checking bench for the receive alarm flag block
// assumes the host model drives apb and the bench drives framer events
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic rx_bit_valid = 1'b0;
   logic rx_bit = 1'b1;
   logic alarm_ind = 1'b0;
   logic seql = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [18:0] fld = 19'h0;
   logic psel, penable, pwrite, pready, pslverr, done, err, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata, v;
   logic [3:0] pstrb;
   int fails = 0;
   int n_compared = 0;
   int e1 = 0;
   int e2 = 0;
   int cnt;

   initial forever #2.5 ref_clk = ~ref_clk;

   e3ri_host_model u_e3ri_host_model (.ref_clk, .rst, .go, .wr, .addr, .wdata, .done,
      .rdata, .err, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr);
   e3ri_rx_alarm_flags u_e3ri_rx_alarm_flags (.ref_clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_bit_valid, .rx_bit,
      .alarm_indication_signal(alarm_ind), .sequence_lost(seql), .frame_alignment_change(ev[0]),
      .out_of_frame_enter(ev[1]), .in_frame_enter(ev[2]), .loss_of_frame_enter(ev[3]),
      .verify_to_in_frame(ev[4]), .frame_valid(ev[5]), .trail_trace_buffer(fld[18:11]),
      .sync_status_message(fld[10:7]), .payload_type(fld[6:4]),
      .error_monitor_byte_error(fld[3]), .framing_byte_error(fld[2]),
      .far_end_block_error_flag(fld[1]), .far_end_receive_failure(fld[0]), .irq);
   // ==========================================================
   // helpers
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task acc(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      {go, wr, addr, wdata} <= {1'b1, w, a, d};
      @(posedge ref_clk);
      go <= 1'b0;
      cnt = 0;
      do
      begin
         @(posedge ref_clk);
         #1 cnt++;
      end while (done !== 1'b1 && cnt < 20);
      chk("done", done, 1);
   endtask
   task rd(logic [7:0] a, int exp);
      acc(1'b0, a, 32'h0);
      chk("rdata", rdata, exp);
   endtask
   task r1;
      rd(8'h50, e1);
      e1 = 0;
   endtask
   task r2;
      rd(8'h54, e2);
      e2 = 0;
   endtask
   task pulse(logic [5:0] p, logic [18:0] f);
      @(posedge ref_clk);
      {ev, fld} <= {p, f};
      @(posedge ref_clk);
      ev <= 6'h00;
   endtask
   task bits(int n, logic b);
      repeat (n)
      begin
         @(posedge ref_clk);
         {rx_bit_valid, rx_bit} <= {1'b1, b};
      end
      @(posedge ref_clk);
      {rx_bit_valid, rx_bit} <= 2'b01;
   endtask
   task print_verdict;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #100000;
      fails++;
      print_verdict;
   end
   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(32'h9eb2));
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 'h40; a <= 'h54; a += 4) rd(8'(a), 0);
      acc(1'b0, 8'h58, 32'h0);
      chk("err", err, 1);
      acc(1'b0, 8'h51, 32'h0);
      chk("err", err, 1);
      v = $urandom;
      acc(1'b1, 8'h4C, v);
      rd(8'h4C, v & 32'h5F);
      acc(1'b1, 8'h48, v);
      rd(8'h48, v & 32'h7F);
      acc(1'b1, 8'h4C, 32'hFF);
      acc(1'b1, 8'h48, 32'hFF);
      pulse(6'h20, 19'h00002);
      e2 |= 'h10;
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", irq, 1);
      r2;
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", irq, 0);
      for (int i = 0; i < 5; i++)
      begin
         pulse(6'(1 << i), fld);
         e1 |= 16 >> ((i + 1) / 2);
         r1;
      end
      r1;
      pulse(6'h20, 19'h4000C);
      e2 |= 'h46;
      r2;
      pulse(6'h20, 19'h00010);
      e2 |= 'h01;
      r2;
      pulse(6'h20, 19'h00290);
      e1 |= 'h40;
      r1;
      acc(1'b1, 8'h40, 32'h1);
      pulse(6'h20, 19'h00010);
      seql <= 1'b1;
      r1;
      acc(1'b1, 8'h40, 32'h2);
      @(posedge ref_clk);
      seql <= 1'b0;
      e1 |= 'h20;
      r1;
      acc(1'b1, 8'h4C, 32'h0);
      pulse(6'h20, 19'h00012);
      e2 |= 'h10;
      repeat (3) @(posedge ref_clk);
      #1 chk("irq", irq, 0);
      r2;
      repeat (4) pulse(6'h20, 19'h00011);
      r2;
      pulse(6'h20, 19'h00011);
      e2 |= 'h08;
      r2;
      // back to three frames: failure state now set, frames with the bit clear
      acc(1'b1, 8'h40, 32'h0);
      repeat (2) pulse(6'h20, 19'h00010);
      r2;
      pulse(6'h20, 19'h00010);
      e2 |= 'h08;
      r2;
      @(posedge ref_clk);
      alarm_ind <= 1'b1;
      e1 |= 'h01;
      r1;
      rd(8'h44, 'h80);
      @(posedge ref_clk);
      alarm_ind <= 1'b0;
      e1 |= 'h01;
      r1;
      bits(31, 1'b0);
      r1;
      bits(1, 1'b0);
      e1 |= 'h02;
      rd(8'h44, 'h40);
      r1;
      bits(32, 1'b1);
      e1 |= 'h02;
      r1;
      rd(8'h44, 'h00);
      print_verdict;
   end
endmodule

`default_nettype wire
